//--- dv/sbo_agent_model.sv
// Far side model: central agent, priority agent and board presence decode
`timescale 1ns/1ps
`default_nettype none

module sbo_agent_model (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Commands from the bench
  input  wire logic       assign_id,
  input  wire logic       prio_want,
  // Processor pins
  input  wire logic       sym_o,
  input  wire logic       sym_oe,
  output var  logic       sym_line,
  output var  logic       priority_bus_request_n,
  input  wire logic       processor_present_n,
  input  wire logic [3:0] voltage_id_code,
  // Board decode
  output var  logic       core_installed,
  output var  logic       socket_empty
);
  logic [2:0] hold_r;                     // Strap cycles left after reset
  logic       system_request_line_zero_n; // Central agent drive of request zero

  ////////////////////////////////////////////////////////////////////////////
  // Strap outlives reset so the processor's synchroniser still sees it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_r <= 3'h5;
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end
  end
  assign system_request_line_zero_n = !(assign_id && hold_r != 3'h0);
  // Pulled-up line: low while either party pulls it low
  assign sym_line = (sym_oe ? sym_o : 1'b1) & system_request_line_zero_n;

  ////////////////////////////////////////////////////////////////////////////
  // Priority agent holds its request while the bench asks for it, one edge after the command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      priority_bus_request_n <= 1'b1;
    end else begin
      priority_bus_request_n <= !prio_want;
    end
  end

  // Socket occupancy from presence and voltage code
  assign core_installed = !processor_present_n && voltage_id_code != 4'hf;
  assign socket_empty   = processor_present_n;
endmodule
`default_nettype wire

//--- dv/sbo_top_tb.sv
// Register-level bench of the bus ownership block
`timescale 1ns/1ps
`default_nettype none
`include "sbo_cfg.svh"

module sbo_top_tb;
  // Clock, reset and bus master drive
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  awaddr = 4'h0;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [3:0]  araddr = 4'h0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [1:0]  bus_speed_select = 2'b01;
  logic        assign_id = 1'b1;
  logic        prio_want = 1'b0;
  // Design outputs and model lines
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        prio_n, sym_line, sym_o, sym_oe, pres_n, agent_id, spd100, config_done;
  logic [3:0]  vid;
  logic        core_installed, socket_empty;
  int          errors = 0;
  int          samples_checked = 0;

  always #5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////
  sbo_top sbo_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .priority_bus_request_n(prio_n), .symmetric_bus_request_n_i(sym_line),
    .symmetric_bus_request_n_o(sym_o), .symmetric_bus_request_n_oe(sym_oe),
    .bus_speed_select(bus_speed_select), .processor_present_n(pres_n),
    .voltage_id_code(vid), .agent_id(agent_id), .bus_speed_100mhz(spd100),
    .config_done(config_done));

  sbo_agent_model sbo_agent_model_i (.aclk(aclk), .aresetn(aresetn), .assign_id(assign_id),
    .prio_want(prio_want), .sym_o(sym_o), .sym_oe(sym_oe), .sym_line(sym_line),
    .priority_bus_request_n(prio_n), .processor_present_n(pres_n),
    .voltage_id_code(vid), .core_installed(core_installed), .socket_empty(socket_empty));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);  // Only the watchdog ends a hang
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask

  // Read: wait for the answer however long it takes
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);  // Only the watchdog ends a hang
    rready <= 1'b0;
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
  endtask

  // Bounded wait for the request enable to reach a level
  task automatic wait_oe(input logic v);
    int n;
    n = 0;
    while (sym_oe !== v && n < 10) begin
      @(posedge aclk);
      n++;
    end
    check({31'h0, sym_oe}, {31'h0, v});
  endtask

  // Reset with a chosen strap and speed code
  task automatic do_reset(input logic asg, input logic [1:0] sel);
    @(posedge aclk);
    aresetn          <= 1'b0;
    assign_id        <= asg;
    bus_speed_select <= sel;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask

  task automatic summarize();
    if (errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    errors++;
    summarize();
  end

  initial begin
    // Both straps and both speed codes, the upper speed bit set against the low one
    for (int i = 0; i < 2; i++) begin
      do_reset(i == 0, i == 0 ? 2'b01 : 2'b10);
      check({31'h0, agent_id}, i);
      check({31'h0, spd100}, 1 - i);
      check({31'h0, config_done}, 32'h1);
      axi_rd(`SBO_STATUS_OFS, 32'h24 | (i << 3) | ((1 - i) << 4), `SBO_RESP_OKAY);
    end
    // Speed code change after release must not move the bus rate
    bus_speed_select <= 2'b01;
    repeat (4) @(posedge aclk);
    check({31'h0, spd100}, 32'h0);
    check({31'h0, pres_n}, 32'h0);
    check({30'h0, core_installed, socket_empty}, 32'h2);
    // Plain request and release
    axi_wr(`SBO_CTRL_OFS, 32'h1, `SBO_RESP_OKAY);
    wait_oe(1'b1);
    check({31'h0, sym_line}, 32'h0);
    axi_rd(`SBO_STATUS_OFS, 32'h2d, `SBO_RESP_OKAY);
    axi_wr(`SBO_CTRL_OFS, 32'h0, `SBO_RESP_OKAY);
    wait_oe(1'b0);
    // Priority owner blocks an unlocked request until it lets go
    prio_want <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(`SBO_STATUS_OFS, 32'h2e, `SBO_RESP_OKAY);
    axi_wr(`SBO_CTRL_OFS, 32'h1, `SBO_RESP_OKAY);
    repeat (10) begin
      @(posedge aclk);
      check({31'h0, sym_oe}, 32'h0);
    end
    prio_want <= 1'b0;
    wait_oe(1'b1);
    axi_wr(`SBO_CTRL_OFS, 32'h0, `SBO_RESP_OKAY);
    wait_oe(1'b0);
    // Locked operation may still request under priority
    prio_want <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_wr(`SBO_CTRL_OFS, 32'h3, `SBO_RESP_OKAY);
    wait_oe(1'b1);
    // Read-only status, unmapped places, control left intact
    axi_wr(`SBO_STATUS_OFS, 32'hffffffff, `SBO_RESP_OKAY);
    axi_rd(`SBO_STATUS_OFS, 32'h2f, `SBO_RESP_OKAY);
    axi_wr(4'h8, 32'h0, `SBO_RESP_SLVERR);
    axi_rd(4'hc, 32'h0, `SBO_RESP_SLVERR);
    axi_rd(`SBO_CTRL_OFS, 32'h3, `SBO_RESP_OKAY);
    summarize();
  end
endmodule
`default_nettype wire

//--- rtl/sbo_cfg.svh
// Offsets, field positions and reset values of the bus ownership block
`ifndef SBO_CFG_SVH
`define SBO_CFG_SVH

// Register byte offsets
`define SBO_CTRL_OFS        4'h0
`define SBO_STATUS_OFS      4'h4

// Control fields
`define SBO_CTRL_NEED_BIT   0
`define SBO_CTRL_LOCK_BIT   1
`define SBO_CTRL_RST        2'h0

// Status fields
`define SBO_ST_OWNER_BIT    0
`define SBO_ST_PRIO_BIT     1
`define SBO_ST_CFG_BIT      2
`define SBO_ST_ID_BIT       3
`define SBO_ST_SPD100_BIT   4
`define SBO_ST_PRES_BIT     5

// Speed select: low bit set picks the 100 MHz bus
`define SBO_SPD_100_BIT     0

// Bus responses
`define SBO_RESP_OKAY       2'h0
`define SBO_RESP_SLVERR     2'h2

// Default voltage code; value is arbitrary and not all ones
`define SBO_VID_DEFAULT     4'h5

`endif

//--- rtl/sbo_pkg.sv
// Types shared by the bus ownership block
package sbo_pkg;

  // Request state machine
  typedef enum logic [1:0] {
    SBO_CFG  = 2'b00,  // Reset window, strap not yet caught
    SBO_IDLE = 2'b01,  // Bus not wanted or request blocked
    SBO_REQ  = 2'b10   // Symmetric request driven
  } sbo_state_t;

endpackage

//--- rtl/sbo_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module sbo_sync #(
  parameter int WIDTH = 1
) (
  // Clock
  input  wire logic             aclk,
  // Pin side and synchronised side
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  // First stage is read only by the second stage
  logic [WIDTH-1:0] meta_r;

  ////////////////////////////////////////////////////////////////////////////
  // No reset, so the pins are followed during reset and the strap is valid
  // at the release edge
  always_ff @(posedge aclk) begin
    meta_r <= d;
    q      <= meta_r;
  end

endmodule

`default_nettype wire

//--- rtl/sbo_top.sv
// Bus ownership and configuration logic of the processor with register slave
`timescale 1ns/1ps
`default_nettype none
`include "sbo_cfg.svh"
// Summary of operation
// - Priority request seen blocks new unlocked requests
// - Speed select low bit one means 100 MHz
// - All agents share one bus frequency
// - Agent ID from request pin at reset release
// - Assert symmetric request when bus is needed
// - Presence output held permanently low
// - Everything on the rising bus clock
module sbo_top #(
  parameter logic [3:0] VID_CODE = `SBO_VID_DEFAULT
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write address channel
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  // Write data channel
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  // Write response channel
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // Read address channel
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  // Read data channel
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // System bus pins
  input  wire logic        priority_bus_request_n,
  input  wire logic        symmetric_bus_request_n_i,
  output var  logic        symmetric_bus_request_n_o,
  output var  logic        symmetric_bus_request_n_oe,
  input  wire logic [1:0]  bus_speed_select,
  output var  logic        processor_present_n,
  output var  logic [3:0]  voltage_id_code,
  // User side status
  output var  logic        agent_id,
  output var  logic        bus_speed_100mhz,
  output var  logic        config_done
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic       prio_s;     // Priority request, active low, synchronised
  logic       sreq_s;     // Own request pin level, synchronised
  logic [1:0] bsel_s;     // Speed select, synchronised
  sbo_sync #(.WIDTH(4)) sbo_sync_i (
    .aclk (aclk),
    .d    ({priority_bus_request_n, symmetric_bus_request_n_i, bus_speed_select}),
    .q    ({prio_s, sreq_s, bsel_s})
  );

  // Priority agent active when its low-true line is low
  logic prio_seen;
  assign prio_seen = ~prio_s;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus state
  logic [1:0]  ctrl_r,   ctrl_nxt;    // Need and lock bits
  logic        aw_full_r, aw_full_nxt; // Write address held
  logic        w_full_r, w_full_nxt;   // Write data held
  logic [3:0]  waddr_r,  waddr_nxt;
  logic [31:0] wdata_r,  wdata_nxt;
  logic        wstrb0_r, wstrb0_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r,  bresp_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  rresp_r,  rresp_nxt;
  logic [31:0] rdata_r,  rdata_nxt;
  logic        do_wr;                  // Both halves present, commit now
  logic [31:0] status_w;               // Live status word
  // Offset check shared by reads and writes
  function automatic logic sbo_mapped(input logic [3:0] a);
    sbo_mapped = (a == `SBO_CTRL_OFS) || (a == `SBO_STATUS_OFS);
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Ownership and configuration state
  sbo_pkg::sbo_state_t state_r, state_nxt;
  logic agent_id_r, agent_id_nxt;     // Captured symmetric agent ID
  logic spd100_r,   spd100_nxt;       // Captured bus speed choice
  logic cfg_r,      cfg_nxt;          // Strap captured
  // Need and lock as seen by the request logic
  logic need;
  logic lock;
  assign need = ctrl_r[`SBO_CTRL_NEED_BIT];
  assign lock = ctrl_r[`SBO_CTRL_LOCK_BIT];
  ////////////////////////////////////////////////////////////////////////////
  // Next state of configuration capture and request machine
  always_comb begin
    state_nxt    = state_r;
    agent_id_nxt = agent_id_r;
    spd100_nxt   = spd100_r;
    cfg_nxt      = 1'b1;
    unique case (state_r)
      sbo_pkg::SBO_CFG: begin
        // First edge after release: strap and speed are taken here
        agent_id_nxt = sreq_s;
        spd100_nxt   = bsel_s[`SBO_SPD_100_BIT];
        state_nxt    = sbo_pkg::SBO_IDLE;
      end
      sbo_pkg::SBO_IDLE: begin
        // New request waits under priority unless a locked sequence runs
        if (need && (!prio_seen || lock)) begin
          state_nxt = sbo_pkg::SBO_REQ;
        end
      end
      sbo_pkg::SBO_REQ: begin
        // Request held while software still wants the bus
        if (!need) begin
          state_nxt = sbo_pkg::SBO_IDLE;
        end
      end
      default: begin
        // Unused code falls back to idle
        state_nxt = sbo_pkg::SBO_IDLE;
      end
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // Rising edge registering of ownership state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= sbo_pkg::SBO_CFG;
      agent_id_r <= 1'b0;
      spd100_r   <= 1'b0;
      cfg_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      agent_id_r <= agent_id_nxt;
      spd100_r   <= spd100_nxt;
      cfg_r      <= cfg_nxt;
    end
  end
  // Drive low only while requesting, so the central agent owns it at config
  assign symmetric_bus_request_n_o  = 1'b0;
  assign symmetric_bus_request_n_oe = (state_r == sbo_pkg::SBO_REQ);
  assign processor_present_n        = 1'b0;
  assign voltage_id_code            = VID_CODE;
  assign agent_id                   = agent_id_r;
  assign bus_speed_100mhz           = spd100_r;
  assign config_done                = cfg_r;
  ////////////////////////////////////////////////////////////////////////////
  // Status word
  always_comb begin
    status_w                     = 32'h0000_0000;
    status_w[`SBO_ST_OWNER_BIT]  = symmetric_bus_request_n_oe;
    status_w[`SBO_ST_PRIO_BIT]   = prio_seen;
    status_w[`SBO_ST_CFG_BIT]    = cfg_r;
    status_w[`SBO_ST_ID_BIT]     = agent_id_r;
    status_w[`SBO_ST_SPD100_BIT] = spd100_r;
    status_w[`SBO_ST_PRES_BIT]   = ~processor_present_n;
  end
  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data held separately, committed together
  assign awready = !aw_full_r && !bvalid_r;
  assign wready  = !w_full_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign do_wr   = aw_full_r && w_full_r;
  always_comb begin
    ctrl_nxt    = ctrl_r;
    aw_full_nxt = aw_full_r;
    w_full_nxt  = w_full_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    // Take address and data in either order
    if (awvalid && awready) begin
      aw_full_nxt = 1'b1;
      waddr_nxt   = awaddr;
    end
    if (wvalid && wready) begin
      w_full_nxt = 1'b1;
      wdata_nxt  = wdata;
      wstrb0_nxt = wstrb[0];
    end
    // Commit; status writes are ignored but answered OKAY
    if (do_wr) begin
      aw_full_nxt = 1'b0;
      w_full_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = sbo_mapped(waddr_r) ? `SBO_RESP_OKAY : `SBO_RESP_SLVERR;
      if (waddr_r == `SBO_CTRL_OFS && wstrb0_r) begin
        ctrl_nxt = wdata_r[1:0];
      end
    end else if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    // Reads answer on the next edge; unmapped reads return zero
    if (arvalid && arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = sbo_mapped(araddr) ? `SBO_RESP_OKAY : `SBO_RESP_SLVERR;
      if (araddr == `SBO_CTRL_OFS) begin
        rdata_nxt = {30'h0000_0000, ctrl_r};
      end else if (araddr == `SBO_STATUS_OFS) begin
        rdata_nxt = status_w;
      end else begin
        rdata_nxt = 32'h0000_0000;
      end
    end else if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Register bus flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r    <= `SBO_CTRL_RST;
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      waddr_r   <= 4'h0;
      wdata_r   <= 32'h0000_0000;
      wstrb0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `SBO_RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= `SBO_RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end else begin
      ctrl_r    <= ctrl_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end
  assign bvalid = bvalid_r;
  assign bresp  = bresp_r;
  assign rvalid = rvalid_r;
  assign rresp  = rresp_r;
  assign rdata  = rdata_r;
  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_cfg_release; $rose(cfg_r); endsequence
  sequence s_req_start; $rose(symmetric_bus_request_n_oe); endsequence
  a_new_req_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    s_req_start |-> $past(!prio_seen || lock))
    else $error("request started while priority agent owned the bus");
  a_agent_id_cap: assert property (@(posedge aclk) disable iff (!aresetn)
    s_cfg_release |-> (agent_id_r == $past(sreq_s)))
    else $error("agent id differs from strap at release");
  a_speed_cap: assert property (@(posedge aclk) disable iff (!aresetn)
    s_cfg_release |-> (spd100_r == $past(bsel_s[0])))
    else $error("speed choice differs from select low bit");
  a_speed_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg_r && $past(cfg_r) |-> $stable(spd100_r))
    else $error("bus speed changed after configuration");
  a_cfg_no_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    !cfg_r |-> !symmetric_bus_request_n_oe)
    else $error("request driven during configuration");
  a_req_on_need: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == sbo_pkg::SBO_IDLE) && need && !prio_seen |=> symmetric_bus_request_n_oe)
    else $error("bus needed but request not raised");
  a_req_release: assert property (@(posedge aclk) disable iff (!aresetn)
    symmetric_bus_request_n_oe && !need |=> !symmetric_bus_request_n_oe)
    else $error("request not released when bus no longer needed");
  a_present_low: assert property (@(posedge aclk) disable iff (!aresetn)
    processor_present_n == 1'b0)
    else $error("presence output not low");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (awvalid && awready) ##0 (wvalid && wready) |=> !bvalid ##1 bvalid)
    else $error("write answer not two edges after both taken");
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped before taken");

endmodule
`default_nettype wire
